// file: esr_event_statistics_reporter.sv
// event statistics reporter: counts, stamps and notifies camera events
// assumes same-clock pulses from trigger, exposure and pulse logic, async pins
// for the input lines, and a control channel transport with a ready handshake
//
// Function
// - selector picks event for count and reset
// - one counter per event, selected one read
// - reset command clears only selected counter
// - events on capture begin and finish
// - frame begin event at exposure delay start
// - frame finish event on frame completion
// - event for each accepted frame trigger
// - disallowed frame trigger dropped, event raised
// - event when picture dropped for memory
// - rejected row trigger: no capture, event
// - postponed row trigger raises its event
// - separate event per input pin change
// - separate event per output pulse start
// - timestamp and data kept per event
// - read-only identifier per event type
// - per-source notify enable gates notifications; overrun is never gated
// - queue overrun disables all, raises overrun
// - input pin edge choice: rise, fall, any
`timescale 1ns/10ps
`include "esr_defs.svh"

module esr_event_statistics_reporter
#(
    parameter logic [`ESR_ID_W-1:0] ID_BASE = 16'h5A00 // arbitrary identifier base
)
(
    input wire logic SYS_CLK_I, // 200 MHz system clock
    input wire logic RESET_N_I, // asynchronous reset, active low
    input wire logic [7:0] ADDR_I, // register byte address
    input wire logic [31:0] WDATA_I, // register write data
    input wire logic WR_I, // write strobe
    input wire logic RD_I, // read strobe
    output logic [31:0] RDATA_O, // read data, cycle after strobe
    input wire logic ACQ_ACTIVE_I, // acquisition running level
    input wire logic EXPO_DELAY_START_I, // exposure delay start of active frame
    input wire logic FRAME_DONE_I, // active frame completed
    input wire logic FRAME_TRIG_I, // frame trigger pulse
    input wire logic ROW_TRIG_I, // line trigger pulse
    input wire logic TRIG_OK_I, // triggering allowed level
    input wire logic PICTURE_DROP_I, // picture lost for lack of memory
    input wire logic [3:0] PULSE_START_I, // pulse start on output lines 3..6
    input wire logic [3:0] PIN_I, // raw input lines 1..4
    output logic FRAME_GO_O, // accepted frame trigger pulse
    output logic ROW_GO_O, // accepted or released line trigger pulse
    output esr_pkg::esr_msg_type MSG_O, // notification toward channel
    input wire logic MSG_READY_I // channel takes notification
);
    import esr_pkg::*;

    localparam logic [`ESR_CNT_W-1:0] CNT_MAX = {`ESR_CNT_W{1'b1}};

    esr_state_type st_reg;
    esr_state_type st_next;
    esr_src_vec_type src;
    esr_evt_vec_type occ;
    esr_evt_vec_type take;
    logic ovr;
    logic [`ESR_NUM_PIN-1:0] pin_evt;
    logic [`ESR_CNT_W-1:0] tally_sel;
    logic pick_ok;
    logic clear_wr;

    // ------------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------------
    // saturating step of an occurrence counter
    function automatic logic [`ESR_CNT_W-1:0] esr_sat_inc(input logic [`ESR_CNT_W-1:0] v);
        esr_sat_inc = (v == CNT_MAX) ? v : v + `ESR_CNT_W'(1);
    endfunction

    // selector value names an existing event
    function automatic logic esr_pick_valid(input logic [`ESR_PICK_W-1:0] p);
        esr_pick_valid = (p < `ESR_PICK_W'(`ESR_NUM_EVT));
    endfunction

    // ------------------------------------------------------------------------
    // input line watcher
    // ------------------------------------------------------------------------
    esr_pin_watch u_pin_watch
    (
        .clk_i(SYS_CLK_I),
        .reset_n_i(RESET_N_I),
        .pin_i(PIN_I),
        .edge_sel_i(st_reg.edge_sel),
        .evt_o(pin_evt)
    );

    // ------------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------------
    // each source is a one-cycle occurrence of its event type
    always_comb
    begin
        src = '0;
        src[`ESR_EV_CAP_BEGIN] = ACQ_ACTIVE_I & ~st_reg.acq_prev;
        src[`ESR_EV_CAP_FINISH] = ~ACQ_ACTIVE_I & st_reg.acq_prev;
        src[`ESR_EV_FRAME_BEGIN] = EXPO_DELAY_START_I;
        src[`ESR_EV_FRAME_FINISH] = FRAME_DONE_I;
        src[`ESR_EV_FRAME_OK] = FRAME_TRIG_I & TRIG_OK_I;
        src[`ESR_EV_FRAME_REJ] = FRAME_TRIG_I & ~TRIG_OK_I;
        src[`ESR_EV_DROP] = PICTURE_DROP_I;
        src[`ESR_EV_ROW_REJ] = ROW_TRIG_I & ~TRIG_OK_I & ~st_reg.postpone_mode;
        src[`ESR_EV_ROW_POST] = ROW_TRIG_I & ~TRIG_OK_I & st_reg.postpone_mode;
        src[`ESR_EV_PIN_LO +: `ESR_NUM_PIN] = pin_evt;
        src[`ESR_EV_PULSE_LO +: 4] = PULSE_START_I;
    end

    // ------------------------------------------------------------------------
    // selected counter and command decode
    // ------------------------------------------------------------------------
    assign pick_ok = esr_pick_valid(st_reg.pick);
    assign tally_sel = pick_ok ? st_reg.cnt[st_reg.pick] : '0;
    assign clear_wr = WR_I && (ADDR_I == `ESR_OFS_CLEAR);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        logic found;
        int k;
        found = 1'b0;
        k = 0;
        st_next = st_reg;
        take = '0;

        // notification sender: lowest pending index goes first
        for (int i = `ESR_NUM_EVT - 1; i >= 0; i--)
        begin
            if (st_reg.pend[i])
            begin
                found = 1'b1;
                k = i;
            end
        end
        if (!st_reg.msg.valid || MSG_READY_I)
        begin
            st_next.msg.valid = found;
            if (found)
            begin
                take[k] = 1'b1;
                st_next.msg.ident = ID_BASE + `ESR_ID_W'(k);
                st_next.msg.stamp = st_reg.stamp[k];
                st_next.msg.data = st_reg.data[k];
            end
        end

        // an enabled event meeting its own unsent slot overruns the queue
        ovr = |(src & st_reg.en & st_reg.pend[`ESR_NUM_SRC-1:0]
            & ~take[`ESR_NUM_SRC-1:0]);
        occ = {ovr, src};

        // register writes
        if (WR_I)
        begin
            if (ADDR_I == `ESR_OFS_PICK)
                st_next.pick = WDATA_I[`ESR_PICK_W-1:0];
            else if (ADDR_I == `ESR_OFS_NOTIFY)
                st_next.en = WDATA_I[`ESR_NUM_SRC-1:0];
            else if (ADDR_I == `ESR_OFS_EDGE)
                st_next.edge_sel = WDATA_I[2*`ESR_NUM_PIN-1:0];
            else if (ADDR_I == `ESR_OFS_CTRL)
                st_next.postpone_mode = WDATA_I[0];
        end

        // counters, stamps and data; a clear with an occurrence in one cycle leaves a count of one
        for (int i = 0; i < `ESR_NUM_EVT; i++)
        begin
            if (clear_wr && pick_ok && (st_reg.pick == `ESR_PICK_W'(i)))
                st_next.cnt[i] = '0;
            if (occ[i])
            begin
                st_next.cnt[i] = esr_sat_inc(st_next.cnt[i]);
                st_next.stamp[i] = st_reg.ts;
                st_next.data[i] = esr_sat_inc(st_next.cnt[i] == CNT_MAX ?
                    CNT_MAX - `ESR_CNT_W'(1) : st_next.cnt[i] - `ESR_CNT_W'(1));
            end
        end

        // pending slots: new occurrence wins over the slot being sent
        st_next.pend = (st_reg.pend & ~take) | (occ & {1'b1, st_reg.en});
        if (ovr)
            st_next.en = '0;

        // frame trigger passes only while triggering is allowed
        st_next.frame_go = FRAME_TRIG_I & TRIG_OK_I;

        // row trigger handling
        st_next.row_go = 1'b0;
        case (st_reg.row_st)
            ESR_ROW_IDLE:
            begin
                if (ROW_TRIG_I && TRIG_OK_I)
                    st_next.row_go = 1'b1;
                else if (ROW_TRIG_I && st_reg.postpone_mode)
                    st_next.row_st = ESR_ROW_HOLD;
            end
            ESR_ROW_HOLD:
            begin
                if (TRIG_OK_I)
                begin
                    st_next.row_go = 1'b1;
                    st_next.row_st = ESR_ROW_IDLE;
                end
            end
            default:
                st_next.row_st = ESR_ROW_IDLE;
        endcase

        st_next.acq_prev = ACQ_ACTIVE_I;
        st_next.ts = st_reg.ts + `ESR_TS_W'(1);

        // read data stand for one cycle only
        st_next.rdata = '0;
        if (RD_I)
        begin
            if (ADDR_I == `ESR_OFS_PICK)
                st_next.rdata = 32'(st_reg.pick);
            else if (ADDR_I == `ESR_OFS_TALLY)
                st_next.rdata = 32'(tally_sel);
            else if (ADDR_I == `ESR_OFS_NOTIFY)
                st_next.rdata = 32'(st_reg.en);
            else if (ADDR_I == `ESR_OFS_EDGE)
                st_next.rdata = 32'(st_reg.edge_sel);
            else if (ADDR_I == `ESR_OFS_CTRL)
                st_next.rdata = 32'(st_reg.postpone_mode);
            else if (ADDR_I == `ESR_OFS_STATUS)
                st_next.rdata = {13'h0000, st_reg.row_st == ESR_ROW_HOLD, st_reg.pend};
            else if (ADDR_I == `ESR_OFS_TIME && pick_ok)
                st_next.rdata = st_reg.stamp[st_reg.pick];
            else if (ADDR_I == `ESR_OFS_DATA && pick_ok)
                st_next.rdata = 32'(st_reg.data[st_reg.pick]);
            else if (ADDR_I == `ESR_OFS_IDENT && pick_ok)
                st_next.rdata = 32'(ID_BASE + `ESR_ID_W'(st_reg.pick));
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            st_reg <= '0;
            st_reg.pick <= `ESR_RST_PICK;
            st_reg.en <= `ESR_RST_NOTIFY;
            st_reg.edge_sel <= `ESR_RST_EDGE;
            st_reg.postpone_mode <= `ESR_RST_CTRL;
            st_reg.row_st <= ESR_ROW_IDLE;
        end
        else
            st_reg <= st_next;
    end

    // outputs
    assign RDATA_O = st_reg.rdata;
    assign FRAME_GO_O = st_reg.frame_go;
    assign ROW_GO_O = st_reg.row_go;
    assign MSG_O = st_reg.msg;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    chk_frame_reject_drop: assert property (
        FRAME_TRIG_I && !TRIG_OK_I |=> !FRAME_GO_O && st_reg.pend[`ESR_EV_FRAME_REJ]
            == ($past(st_reg.en[`ESR_EV_FRAME_REJ]) || $past(st_reg.pend[`ESR_EV_FRAME_REJ])
            && !$past(take[`ESR_EV_FRAME_REJ])))
        else $error("rejected frame trigger mishandled");

    chk_frame_accept_go: assert property (
        FRAME_TRIG_I && TRIG_OK_I |=> FRAME_GO_O ##1 !FRAME_GO_O || $past(FRAME_TRIG_I))
        else $error("accepted frame trigger not passed");

    chk_tally_clear_sel: assert property (
        clear_wr && pick_ok && !occ[st_reg.pick] |=> tally_sel == '0)
        else $error("selected counter not cleared");

    chk_tally_step_one: assert property (
        !WR_I && pick_ok && occ[st_reg.pick] && tally_sel != CNT_MAX
            |=> tally_sel == $past(tally_sel) + `ESR_CNT_W'(1))
        else $error("counter did not step by one");

    chk_tally_saturate: assert property (
        !WR_I && pick_ok && tally_sel == CNT_MAX |=> tally_sel == CNT_MAX)
        else $error("counter wrapped");

    chk_tally_read_value: assert property (
        RD_I && ADDR_I == `ESR_OFS_TALLY |=> RDATA_O == 32'($past(tally_sel)))
        else $error("count read wrong value");

    chk_notify_gate_off: assert property (
        ((st_next.pend & ~st_reg.pend) & ~{1'b1, st_reg.en}) == '0)
        else $error("disabled event queued");

    chk_overrun_kill_all: assert property (
        ovr |=> st_reg.en == '0 && st_reg.pend[`ESR_EV_OVERRUN] ##1 !$rose(|st_reg.en)
            || $past(WR_I))
        else $error("overrun did not disable events");

    chk_row_reject_none: assert property (
        ROW_TRIG_I && !TRIG_OK_I && !st_reg.postpone_mode
            && st_reg.row_st == ESR_ROW_IDLE |=> !ROW_GO_O)
        else $error("rejected row trigger started capture");

    chk_row_hold_release: assert property (
        st_reg.row_st == ESR_ROW_HOLD && TRIG_OK_I |=> ROW_GO_O && st_reg.row_st == ESR_ROW_IDLE)
        else $error("postponed row trigger not released");

    chk_msg_ident_range: assert property (
        $rose(MSG_O.valid) |-> MSG_O.ident >= ID_BASE
            && MSG_O.ident < ID_BASE + `ESR_ID_W'(`ESR_NUM_EVT))
        else $error("notification identifier out of range");

endmodule // esr_event_statistics_reporter

// file: esr_defs.svh
// constants of the event statistics reporter: register offsets, reset values,
// field widths and event indices
// assumes inclusion by the package, the design modules and the testbench
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ESR_OFS_PICK 8'h00
`define ESR_OFS_TALLY 8'h04
`define ESR_OFS_CLEAR 8'h08
`define ESR_OFS_NOTIFY 8'h0C
`define ESR_OFS_EDGE 8'h10
`define ESR_OFS_CTRL 8'h14
`define ESR_OFS_STATUS 8'h18
`define ESR_OFS_TIME 8'h1C
`define ESR_OFS_DATA 8'h20
`define ESR_OFS_IDENT 8'h24

// ----------------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------------
`define ESR_NUM_SRC 17
`define ESR_NUM_EVT 18
`define ESR_NUM_PIN 4
`define ESR_PICK_W 5
`define ESR_CNT_W 16
`define ESR_TS_W 32
`define ESR_ID_W 16

// ----------------------------------------------------------------------------
// event indices
// ----------------------------------------------------------------------------
`define ESR_EV_CAP_BEGIN 0
`define ESR_EV_CAP_FINISH 1
`define ESR_EV_FRAME_BEGIN 2
`define ESR_EV_FRAME_FINISH 3
`define ESR_EV_FRAME_OK 4
`define ESR_EV_FRAME_REJ 5
`define ESR_EV_DROP 6
`define ESR_EV_ROW_REJ 7
`define ESR_EV_ROW_POST 8
`define ESR_EV_PIN_LO 9
`define ESR_EV_PULSE_LO 13
`define ESR_EV_OVERRUN 17

// ----------------------------------------------------------------------------
// reset values and edge choice codes
// ----------------------------------------------------------------------------
`define ESR_RST_PICK 5'h00
`define ESR_RST_NOTIFY 17'h00000
`define ESR_RST_EDGE 8'hFF
`define ESR_RST_CTRL 1'h0
`define ESR_EDGE_RISE_BIT 0
`define ESR_EDGE_FALL_BIT 1

`endif

// file: esr_pkg.sv
// types of the event statistics reporter
// assumes esr_defs.svh in the include path
`include "esr_defs.svh"

package esr_pkg;

    // row trigger handling states
    typedef enum logic [1:0] {
        ESR_ROW_IDLE = 2'h1,
        ESR_ROW_HOLD = 2'h2
    } esr_row_state_type;

    typedef logic [`ESR_NUM_SRC-1:0] esr_src_vec_type;
    typedef logic [`ESR_NUM_EVT-1:0] esr_evt_vec_type;

    // one notification toward the control channel
    typedef struct packed {
        logic valid;
        logic [`ESR_ID_W-1:0] ident;
        logic [`ESR_TS_W-1:0] stamp;
        logic [`ESR_CNT_W-1:0] data;
    } esr_msg_type;

    // whole state of the reporter
    typedef struct packed {
        logic [`ESR_PICK_W-1:0] pick;
        esr_src_vec_type en;
        logic [2*`ESR_NUM_PIN-1:0] edge_sel;
        logic postpone_mode;
        esr_evt_vec_type pend;
        logic [`ESR_NUM_EVT-1:0][`ESR_CNT_W-1:0] cnt;
        logic [`ESR_NUM_EVT-1:0][`ESR_TS_W-1:0] stamp;
        logic [`ESR_NUM_EVT-1:0][`ESR_CNT_W-1:0] data;
        logic [`ESR_TS_W-1:0] ts;
        logic acq_prev;
        esr_row_state_type row_st;
        logic frame_go;
        logic row_go;
        esr_msg_type msg;
        logic [31:0] rdata;
    } esr_state_type;

    // whole state of the input pin watcher
    typedef struct packed {
        logic [`ESR_NUM_PIN-1:0] s1;
        logic [`ESR_NUM_PIN-1:0] s2;
        logic [`ESR_NUM_PIN-1:0] s3;
        logic [`ESR_NUM_PIN-1:0] evt;
    } esr_pin_state_type;

endpackage

// file: esr_pin_watch.sv
// input pin watcher: synchronises the input lines and flags chosen edges
// assumes asynchronous pins and a 2-bit edge choice per pin from registers
`timescale 1ns/10ps
`include "esr_defs.svh"

module esr_pin_watch
(
    input wire logic clk_i, // system clock
    input wire logic reset_n_i, // asynchronous reset, active low
    input wire logic [`ESR_NUM_PIN-1:0] pin_i, // raw input lines
    input wire logic [2*`ESR_NUM_PIN-1:0] edge_sel_i, // edge choice per pin
    output logic [`ESR_NUM_PIN-1:0] evt_o // one-cycle edge events
);
    import esr_pkg::*;

    esr_pin_state_type st_reg;
    esr_pin_state_type st_next;

    // ------------------------------------------------------------------------
    // synchroniser and edge selection
    // ------------------------------------------------------------------------
    // s1 feeds only s2; edges are seen between s2 and s3
    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < `ESR_NUM_PIN; i++)
        begin
            st_next.evt[i] = (edge_sel_i[2*i+`ESR_EDGE_RISE_BIT] & st_reg.s2[i] & ~st_reg.s3[i])
                | (edge_sel_i[2*i+`ESR_EDGE_FALL_BIT] & ~st_reg.s2[i] & st_reg.s3[i]);
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign evt_o = st_reg.evt;

endmodule // esr_pin_watch

// file: esr_channel_sink.sv
// channel sink model: the far side that takes notifications from the reporter
// assumes one clock shared with the reporter and a valid/ready transfer
`timescale 1ns/10ps

module esr_channel_sink
(
    input wire logic clk_i, // system clock
    input wire logic reset_n_i, // asynchronous reset, active low
    input wire esr_pkg::esr_msg_type msg_i, // notification from the reporter
    input wire logic stall_i, // refuse every transfer
    input wire logic slow_i, // accept only every other cycle
    output logic ready_o // ready toward the reporter
);
    import esr_pkg::*;

    // ------------------------------------------------------------------
    // capture of transfers
    // ------------------------------------------------------------------
    esr_msg_type got[$]; // notifications taken so far
    logic phase_reg;

    // ready changes only after an edge, so the reporter sees it settled
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ready_o <= 1'b0;
            phase_reg <= 1'b0;
        end
        else
        begin
            if (msg_i.valid && ready_o)
                got.push_back(msg_i); // taken at the valid and ready edge
            phase_reg <= ~phase_reg;
            ready_o <= !stall_i && (!slow_i || phase_reg);
        end
    end
endmodule // esr_channel_sink

// file: esr_event_statistics_reporter_tb.sv
// testbench of the event statistics reporter with a counting model
// assumes the reporter, the channel sink model and the shared constants
`timescale 1ns/10ps
`include "esr_defs.svh"

module esr_event_statistics_reporter_tb;
    import esr_pkg::*;

    // ------------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------------
    localparam logic [15:0] ID_BASE = 16'h5A00; // arbitrary identifier base
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0, rd = 1'b0, acq = 1'b0, expo = 1'b0, done = 1'b0;
    logic ftrig = 1'b0, rtrig = 1'b0, tok = 1'b0, drop = 1'b0;
    logic stall = 1'b0, slow = 1'b0;
    logic [3:0] pulse = 4'h0, pin = 4'h0;
    logic frame_go, row_go, ready;
    logic [31:0] rdata, val;
    logic [15:0] lfsr = 16'h0019;
    logic [7:0] edge_cfg = 8'hFF;
    esr_msg_type msg;
    int cnt[18];
    int miscompares = 0, num_checks = 0;

    // clock at 200 MHz
    always #2.5 clk = ~clk;

    esr_event_statistics_reporter #(.ID_BASE(ID_BASE)) u_dut (.SYS_CLK_I(clk),
        .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .ACQ_ACTIVE_I(acq), .EXPO_DELAY_START_I(expo),
        .FRAME_DONE_I(done), .FRAME_TRIG_I(ftrig), .ROW_TRIG_I(rtrig), .TRIG_OK_I(tok),
        .PICTURE_DROP_I(drop), .PULSE_START_I(pulse), .PIN_I(pin),
        .FRAME_GO_O(frame_go), .ROW_GO_O(row_go), .MSG_O(msg), .MSG_READY_I(ready));

    esr_channel_sink u_sink (.clk_i(clk), .reset_n_i(rst_n), .msg_i(msg),
        .stall_i(stall), .slow_i(slow), .ready_o(ready));

    // ------------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task results;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        val = rdata;
    endtask

    // one occurrence of event kind k, with the model following it
    task fire(input int k);
        int p;
        p = k - 9;
        @(posedge clk);
        case (k)
            0: acq <= 1'b1;
            1: acq <= 1'b0;
            2: expo <= 1'b1;
            3: done <= 1'b1;
            4, 5: ftrig <= 1'b1;
            6: drop <= 1'b1;
            7, 8: rtrig <= 1'b1;
            9, 10, 11, 12: pin[p] <= ~pin[p];
            default: pulse[k-13] <= 1'b1;
        endcase
        if (k == 4 || k == 5 || k == 7 || k == 8)
            tok <= (k == 4);
        @(posedge clk);
        {expo, done, ftrig, drop, rtrig, pulse} <= '0;
        #1;
        if (k == 4 || k == 5)
            check(frame_go, k == 4);
        if (k == 7 || k == 8)
            check(row_go, 1'b0);
        if (k < 9 || k > 12 || (pin[p] && edge_cfg[2*p]) || (!pin[p] && edge_cfg[2*p+1]))
            cnt[k] = (cnt[k] < 65535) ? cnt[k] + 1 : 65535;
        if (k >= 9 && k <= 12)
            repeat (4) @(posedge clk);
    endtask

    // every counter and identifier through the selector
    task check_all;
        for (int k = 0; k < 18; k++)
        begin
            wr_reg(`ESR_OFS_PICK, k);
            rd_reg(`ESR_OFS_PICK);
            check(val, k);
            rd_reg(`ESR_OFS_TALLY);
            check(val, cnt[k]);
            rd_reg(`ESR_OFS_IDENT);
            check(val, ID_BASE + k);
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`ESR_OFS_PICK);
        check(val, 32'h0);
        rd_reg(`ESR_OFS_NOTIFY);
        check(val, 32'h0);
        rd_reg(`ESR_OFS_EDGE);
        check(val, 32'hFF);
        rd_reg(8'h40);
        check(val, 32'h0);
        fire(0);
        fire(1);
        // random mix of the simple sources
        for (int i = 0; i < 60; i++)
        begin
            lfsr = lfsr_next(lfsr);
            fire((int'(lfsr % 15) + 2 == 7 || int'(lfsr % 15) + 2 == 8) ? 4 : int'(lfsr % 15) + 2);
        end
        fire(7);
        wr_reg(`ESR_OFS_CTRL, 32'h1);
        rd_reg(`ESR_OFS_CTRL);
        check(val, 32'h1);
        fire(8);
        @(posedge clk);
        tok <= 1'b1;
        @(posedge clk);
        #1;
        check(row_go, 1'b1);
        wr_reg(`ESR_OFS_EDGE, 32'hFD);
        edge_cfg = 8'hFD;
        fire(9);
        fire(9);
        check_all;
        // clearing acts on the selected counter only
        wr_reg(`ESR_OFS_PICK, 32'h4);
        wr_reg(`ESR_OFS_CLEAR, {16'h0000, lfsr}); // any data clears
        cnt[4] = 0;
        check_all;
        // notifications through a slow channel
        slow <= 1'b1;
        wr_reg(`ESR_OFS_NOTIFY, 32'hC);
        fire(2);
        fire(3);
        fire(6);
        repeat (10) @(posedge clk);
        check(u_sink.got.size(), 32'h2);
        check(u_sink.got[0].ident, ID_BASE + 2);
        check(u_sink.got[0].data, cnt[2]);
        check(u_sink.got[1].ident, ID_BASE + 3);
        check(u_sink.got[1].data, cnt[3]);
        check(u_sink.got[1].stamp - u_sink.got[0].stamp, 32'h2);
        // stored data and stamp of the picked event
        wr_reg(`ESR_OFS_PICK, 32'h2);
        rd_reg(`ESR_OFS_DATA);
        check(val, cnt[2]);
        rd_reg(`ESR_OFS_TIME);
        check(val, u_sink.got[0].stamp);
        // overrun while the channel refuses
        stall <= 1'b1;
        wr_reg(`ESR_OFS_NOTIFY, 32'h40);
        repeat (3) fire(6);
        rd_reg(`ESR_OFS_NOTIFY);
        check(val, 32'h0);
        // unsent slot of event 6 and the overrun slot stay pending
        rd_reg(`ESR_OFS_STATUS);
        check(val, 32'h00020040);
        cnt[17]++; // the overrun is counted like any other event
        stall <= 1'b0;
        repeat (20) @(posedge clk);
        check(u_sink.got[$].ident, ID_BASE + 17);
        // saturation of a counter held busy, selected so the counter checks watch it
        wr_reg(`ESR_OFS_PICK, 32'h6);
        @(posedge clk);
        drop <= 1'b1;
        repeat (65540) @(posedge clk);
        drop <= 1'b0;
        cnt[6] = 65535;
        check_all;
        results;
    end

    // watchdog against a hang
    initial
    begin
        #450000;
        miscompares++;
        results;
    end
endmodule // esr_event_statistics_reporter_tb
